// ### pcs_defines.vh
// Purpose: Constants for the command and status configuration word pair
// Assumes: Configuration dword at offset 0x04, command low half, status high
// Notes: Included by the register module only, not by the flag or error driver modules
`ifndef PCS_DEFINES_VH
`define PCS_DEFINES_VH

// Configuration dword holding command and status
`define PCS_CMD_OFFSET 8'h04
`define PCS_STS_OFFSET 8'h06
`define PCS_CMD_RESET 16'h0000
`define PCS_STS_RESET 16'h0210

// Command word fields
`define PCS_CMD_IO_SPACE 0
`define PCS_CMD_MEM_RESP 1
`define PCS_CMD_BUS_MASTER 2
`define PCS_CMD_SPECIAL 3
`define PCS_CMD_INV_WRITE 4
`define PCS_CMD_PALETTE 5
`define PCS_CMD_PARITY_RESP 6
`define PCS_CMD_STEPPING 7
`define PCS_CMD_SIGNALLED_SYSTEM_ERROR 8
`define PCS_CMD_B2B_GEN 9
`define PCS_CMD_WR_MASK 16'h0156

// Status word fields
`define PCS_STS_CAP_LIST 4
`define PCS_STS_FAST_CLK 5
`define PCS_STS_USER_FEAT 6
`define PCS_STS_B2B_CAP 7
`define PCS_STS_MST_DPE 8
`define PCS_STS_SEL_LSB 9
`define PCS_STS_SEL_MSB 10
`define PCS_STS_SIG_TABORT 11
`define PCS_STS_RCV_TABORT 12
`define PCS_STS_RCV_RECEIVED_MASTER_ABORT 13
`define PCS_STS_SIG_SERR 14
`define PCS_STS_DET_PERR 15
`define PCS_STS_FIXED 16'h0210
`define PCS_SEL_TIMING_MEDIUM 2'b01

// Bus command codes for master writes
`define PCS_BUSCMD_MEM_WRITE 4'h7
`define PCS_BUSCMD_MEM_WRITE_INV 4'hF

// Clock cycles from address phase to select, medium decode
`define PCS_SEL_DELAY 2

`endif

// ### pcs_sticky_flags.v
// Purpose: Bank of hardware-set, write-one-to-clear flags
// Assumes: Set and clear are single-cycle strobes in the clock domain
// Notes: Set wins when both arrive on the same edge
`timescale 1ns/1ps
`default_nettype none

module pcs_sticky_flags #(
  parameter WIDTH = 6
) (
  input wire i_clk,
  input wire i_rst,
  input wire [WIDTH-1:0] i_set,
  input wire [WIDTH-1:0] i_clear,
  output reg [WIDTH-1:0] o_flags
);

  wire [WIDTH-1:0] next_flags;

  // Clear by one, zero keeps, set wins
  assign next_flags = (o_flags & ~i_clear) | i_set;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flags <= {WIDTH{1'b0}};
    end else begin
      o_flags <= next_flags;
    end
  end

endmodule // pcs_sticky_flags

`default_nettype wire

// ### pcs_error_driver.v
// Purpose: Open-drain error line driver, one-clock low pulse
// Assumes: Event strobe is one cycle wide
// Notes: Pin level is resolved outside from the enable
`timescale 1ns/1ps
`default_nettype none

module pcs_error_driver (
  input wire i_clk,
  input wire i_rst,
  input wire i_enable,
  input wire i_event,
  output reg o_drive_oe,
  output wire o_drive_out,
  output wire o_signalled
);

  wire next_drive;

  // Only an enabled driver may pull the line
  assign next_drive = i_event & i_enable;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_drive_oe <= 1'b0;
    end else begin
      o_drive_oe <= next_drive;
    end
  end

  // Open drain: output value is always low
  assign o_drive_out = 1'b0;
  assign o_signalled = o_drive_oe;

endmodule // pcs_error_driver

`default_nettype wire

// ### pcs_cmd_status_regs.v
// Purpose: Command and status configuration words of a bus function
// Assumes: Configuration access strobes are synchronous to I_MCLK
// Notes: Other configuration dwords read as zero here
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.vh"

module pcs_cmd_status_regs (
  input wire I_MCLK,
  input wire I_RST,
  // Configuration access port
  input wire I_CFG_WR,
  input wire I_CFG_RD,
  input wire [7:0] I_CFG_ADDR,
  input wire [3:0] I_CFG_BE,
  input wire [31:0] I_CFG_WDATA,
  output reg [31:0] O_CFG_RDATA,
  output reg O_CFG_ACK,
  // Parity and abort events from the bus engine
  input wire I_ADDR_PARITY_ERR,
  input wire I_DATA_PARITY_ERR,
  input wire I_PARITY_ERROR_LINE_SEEN,
  input wire I_MASTER_DATA_PHASE,
  input wire I_MASTER_ABORT,
  input wire I_TARGET_ABORT_RCVD,
  input wire I_TARGET_ABORT_SENT,
  // Master request path
  input wire I_MASTER_REQ,
  input wire I_MASTER_LINE_WRITE,
  output reg O_MASTER_START,
  output reg [3:0] O_MASTER_CMD,
  // Target claim path
  input wire I_MEM_ADDR_HIT,
  output reg O_DEVICE_SELECT_LINE_OUT,
  output reg O_DEVICE_SELECT_LINE_OE,
  // Open-drain error lines
  output wire O_SYSTEM_ERROR_OUT,
  output wire O_SYSTEM_ERROR_OUT_OE,
  output wire O_PARITY_ERROR_LINE_OUT,
  output wire O_PARITY_ERROR_LINE_OE,
  // Enables for the rest of the function
  output wire O_BUS_MASTER_ENABLE,
  output wire O_MEMORY_RESPONSE_ENABLE
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane write merge
  function [7:0] lane_merge;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] wr_mask;
    input lane_en;
    begin
      if (lane_en) begin
        lane_merge = (old_val & ~wr_mask) | (new_val & wr_mask);
      end else begin
        lane_merge = old_val;
      end
    end
  endfunction

  // Write-one-to-clear strobe for one byte lane
  function [7:0] lane_clear;
    input [7:0] new_val;
    input lane_en;
    input hit;
    begin
      if (lane_en && hit) begin
        lane_clear = new_val;
      end else begin
        lane_clear = 8'h00;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  reg cfg_hit;

  always @* begin
    if (I_CFG_ADDR == `PCS_CMD_OFFSET) begin
      cfg_hit = 1'b1;
    end else begin
      cfg_hit = 1'b0;
    end
  end

  wire cfg_write;
  assign cfg_write = I_CFG_WR & cfg_hit;

  wire cfg_read;
  assign cfg_read = I_CFG_RD & cfg_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Command word

  reg [15:0] command;
  reg [15:0] next_command;
  wire [15:0] cmd_mask;

  assign cmd_mask = `PCS_CMD_WR_MASK;

  always @* begin
    next_command = command;
    if (cfg_write) begin
      next_command[7:0] = lane_merge(command[7:0], I_CFG_WDATA[7:0],
                                     cmd_mask[7:0], I_CFG_BE[0]);
      next_command[15:8] = lane_merge(command[15:8], I_CFG_WDATA[15:8],
                                      cmd_mask[15:8], I_CFG_BE[1]);
    end
    // Read-only positions forced to zero
    next_command = next_command & cmd_mask;
  end

  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      command <= `PCS_CMD_RESET;
    end else begin
      command <= next_command;
    end
  end

  wire system_error_enable;
  wire parity_response_enable;
  wire invalidate_write_enable;
  wire bus_master_enable;
  wire memory_response_enable;

  assign system_error_enable = command[`PCS_CMD_SIGNALLED_SYSTEM_ERROR];
  assign parity_response_enable = command[`PCS_CMD_PARITY_RESP];
  assign invalidate_write_enable = command[`PCS_CMD_INV_WRITE];
  assign bus_master_enable = command[`PCS_CMD_BUS_MASTER];
  assign memory_response_enable = command[`PCS_CMD_MEM_RESP];

  assign O_BUS_MASTER_ENABLE = bus_master_enable;
  assign O_MEMORY_RESPONSE_ENABLE = memory_response_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Error line drivers

  wire serr_signalled;
  wire serr_drive_out;
  wire perr_drive_out;

  // Address parity error raises system error when enabled
  pcs_error_driver u_serr (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_enable(system_error_enable),
    .i_event(I_ADDR_PARITY_ERR),
    .o_drive_oe(O_SYSTEM_ERROR_OUT_OE),
    .o_drive_out(serr_drive_out),
    .o_signalled(serr_signalled)
  );

  // Data parity error raises parity line when enabled
  pcs_error_driver u_perr (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_enable(parity_response_enable),
    .i_event(I_DATA_PARITY_ERR),
    .o_drive_oe(O_PARITY_ERROR_LINE_OE),
    .o_drive_out(perr_drive_out),
    .o_signalled()
  );

  assign O_SYSTEM_ERROR_OUT = serr_drive_out;
  assign O_PARITY_ERROR_LINE_OUT = perr_drive_out;

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  // Flag order: 0 master parity, 1 sig abort, 2 rcv abort,
  // 3 master abort, 4 system error, 5 detected parity
  wire [5:0] flag_set;
  wire [5:0] flag_clear;
  wire [5:0] flags;
  wire [7:0] sts_hi_clear;

  assign flag_set[0] = I_PARITY_ERROR_LINE_SEEN & I_MASTER_DATA_PHASE
                       & parity_response_enable;
  assign flag_set[1] = I_TARGET_ABORT_SENT;
  assign flag_set[2] = I_TARGET_ABORT_RCVD;
  assign flag_set[3] = I_MASTER_ABORT;
  assign flag_set[4] = serr_signalled & system_error_enable;
  assign flag_set[5] = I_ADDR_PARITY_ERR | I_DATA_PARITY_ERR;

  // Status high byte in lane 3; lane 2 holds only fixed bits
  assign sts_hi_clear = lane_clear(I_CFG_WDATA[31:24], I_CFG_BE[3], cfg_write);

  assign flag_clear[0] = sts_hi_clear[`PCS_STS_MST_DPE - 8];
  assign flag_clear[1] = sts_hi_clear[`PCS_STS_SIG_TABORT - 8];
  assign flag_clear[2] = sts_hi_clear[`PCS_STS_RCV_TABORT - 8];
  assign flag_clear[3] = sts_hi_clear[`PCS_STS_RCV_RECEIVED_MASTER_ABORT - 8];
  assign flag_clear[4] = sts_hi_clear[`PCS_STS_SIG_SERR - 8];
  assign flag_clear[5] = sts_hi_clear[`PCS_STS_DET_PERR - 8];

  pcs_sticky_flags #(
    .WIDTH(6)
  ) u_flags (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_set(flag_set),
    .i_clear(flag_clear),
    .o_flags(flags)
  );

  // Status word image
  reg [15:0] status;

  always @* begin
    // Fixed bits first, then the hardware-set flags
    status = `PCS_STS_FIXED;
    status[`PCS_STS_SEL_MSB:`PCS_STS_SEL_LSB] = `PCS_SEL_TIMING_MEDIUM;
    status[`PCS_STS_MST_DPE] = flags[0];
    status[`PCS_STS_SIG_TABORT] = flags[1];
    status[`PCS_STS_RCV_TABORT] = flags[2];
    status[`PCS_STS_RCV_RECEIVED_MASTER_ABORT] = flags[3];
    status[`PCS_STS_SIG_SERR] = flags[4];
    status[`PCS_STS_DET_PERR] = flags[5];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration read

  reg [31:0] next_rdata;
  wire next_ack;

  assign next_ack = I_CFG_RD | I_CFG_WR;

  always @* begin
    if (cfg_read) begin
      next_rdata = {status, command};
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_CFG_RDATA <= 32'h0000_0000;
      O_CFG_ACK <= 1'b0;
    end else begin
      O_CFG_RDATA <= next_rdata;
      O_CFG_ACK <= next_ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master request gating and command choice

  reg [3:0] next_master_cmd;
  wire next_start;

  // Master cycles start only while mastering is enabled
  assign next_start = I_MASTER_REQ & bus_master_enable;

  always @* begin
    if (I_MASTER_LINE_WRITE && invalidate_write_enable) begin
      next_master_cmd = `PCS_BUSCMD_MEM_WRITE_INV;
    end else begin
      next_master_cmd = `PCS_BUSCMD_MEM_WRITE;
    end
  end

  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_MASTER_START <= 1'b0;
      O_MASTER_CMD <= `PCS_BUSCMD_MEM_WRITE;
    end else begin
      O_MASTER_START <= next_start;
      O_MASTER_CMD <= next_master_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory claim with medium decode timing

  reg [`PCS_SEL_DELAY-1:0] claim_pipe;
  wire next_claim;
  wire next_select;

  // Special cycles never reach this path
  assign next_claim = I_MEM_ADDR_HIT & memory_response_enable;

  // Select stands one cycle per hit
  assign next_select = claim_pipe[`PCS_SEL_DELAY-2];

  always @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      claim_pipe <= {`PCS_SEL_DELAY{1'b0}};
      O_DEVICE_SELECT_LINE_OE <= 1'b0;
      O_DEVICE_SELECT_LINE_OUT <= 1'b1;
    end else begin
      claim_pipe <= {claim_pipe[`PCS_SEL_DELAY-2:0], next_claim};
      // Select driven on the second edge after the hit
      O_DEVICE_SELECT_LINE_OE <= next_select;
      O_DEVICE_SELECT_LINE_OUT <= ~next_select;
    end
  end

endmodule // pcs_cmd_status_regs

`default_nettype wire

// ### pcs_cmd_status_regs_properties.sv
// Purpose: Port assertions for the command and status words
// Assumes: One clock, asynchronous active-high reset
// Notes: Bound to the design top by the testbench
`timescale 1ns/1ps
`default_nettype none
module pcs_cmd_status_regs_properties (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_CFG_WR,
  input wire logic I_CFG_RD,
  input wire logic [7:0] I_CFG_ADDR,
  input wire logic [31:0] O_CFG_RDATA,
  input wire logic I_ADDR_PARITY_ERR,
  input wire logic I_DATA_PARITY_ERR,
  input wire logic I_MASTER_ABORT,
  input wire logic I_MASTER_REQ,
  input wire logic I_MASTER_LINE_WRITE,
  input wire logic O_MASTER_START,
  input wire logic [3:0] O_MASTER_CMD,
  input wire logic I_MEM_ADDR_HIT,
  input wire logic O_DEVICE_SELECT_LINE_OUT,
  input wire logic O_DEVICE_SELECT_LINE_OE,
  input wire logic O_SYSTEM_ERROR_OUT_OE,
  input wire logic O_PARITY_ERROR_LINE_OE,
  input wire logic O_BUS_MASTER_ENABLE,
  input wire logic O_MEMORY_RESPONSE_ENABLE
);
  wire logic rd_hit = I_CFG_RD & ~I_CFG_WR & (I_CFG_ADDR == 8'h04);
  wire logic claim_req = I_MEM_ADDR_HIT & O_MEMORY_RESPONSE_ENABLE;
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  sequence s_selected;
    (O_DEVICE_SELECT_LINE_OE && !O_DEVICE_SELECT_LINE_OUT) ##1 !O_DEVICE_SELECT_LINE_OE;
  endsequence
  sequence s_abort_read;
    I_MASTER_ABORT ##1 (!I_CFG_WR) [*2] ##1 rd_hit;
  endsequence
  AST_CMD_FIXED: assert property (
    rd_hit |=> (O_CFG_RDATA[15:0] & 16'hfea9) == 16'h0000)
    else $error("command fixed bits");
  AST_STS_FIXED: assert property (
    rd_hit |=> (O_CFG_RDATA[31:16] & 16'h06ff) == 16'h0210)
    else $error("status fixed bits");
  AST_SERR_CAUSE: assert property (O_SYSTEM_ERROR_OUT_OE |-> $past(I_ADDR_PARITY_ERR))
    else $error("stray system error");
  AST_PERR_CAUSE: assert property (O_PARITY_ERROR_LINE_OE |-> $past(I_DATA_PARITY_ERR))
    else $error("stray parity error");
  AST_MASTER_GATE: assert property (
    I_MASTER_REQ |=> O_MASTER_START == $past(O_BUS_MASTER_ENABLE))
    else $error("master start gating");
  AST_MASTER_CAUSE: assert property (O_MASTER_START |-> $past(I_MASTER_REQ))
    else $error("stray master start");
  AST_PLAIN_WRITE: assert property (!I_MASTER_LINE_WRITE |=> O_MASTER_CMD == 4'h7)
    else $error("write command code");
  AST_CLAIM: assert property (claim_req |-> ##2 s_selected)
    else $error("claim timing");
  AST_NO_CLAIM: assert property (O_DEVICE_SELECT_LINE_OE |-> $past(claim_req, 2))
    else $error("stray claim");
  AST_ABORT_FLAG: assert property (s_abort_read |=> O_CFG_RDATA[29])
    else $error("abort flag missing");
endmodule // pcs_cmd_status_regs_properties
`default_nettype wire

// ### pcs_bus_agent.sv
// Purpose: Far-side bus agents and pulled-up shared lines
// Assumes: Event requests change at the falling edge
// Notes: Another agent may pull the parity line itself
`timescale 1ns/1ps
`default_nettype none
module pcs_bus_agent (
  input wire logic i_clk,
  input wire logic [5:0] i_fire,
  input wire logic i_perr_oe,
  input wire logic i_serr_oe,
  input wire logic i_sel_oe,
  input wire logic i_sel_out,
  output logic [4:0] o_evt,
  output logic o_line_seen,
  output logic o_perr_n,
  output logic o_serr_n,
  output logic o_sel_n
);
  logic drive_perr = 1'b0;
  initial o_line_seen = 1'b0;
  // Released lines float high
  assign o_perr_n = ~(i_perr_oe | drive_perr);
  assign o_serr_n = ~i_serr_oe;
  assign o_sel_n = ~(i_sel_oe & ~i_sel_out);
  assign o_evt = i_fire[4:0];
  always @(posedge i_clk) drive_perr <= i_fire[5];
  always @(negedge i_clk) o_line_seen <= ~o_perr_n;
endmodule // pcs_bus_agent
`default_nettype wire

// ### pcs_cmd_status_regs_tb.sv
// Purpose: Self-checking bench for the command and status words
// Assumes: Inputs change at the falling clock edge
// Notes: Random traffic from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module pcs_cmd_status_regs_tb;
  logic I_MCLK = 1'b0;
  logic I_RST = 1'b1;
  logic wr = 1'b0, rd = 1'b0, req = 1'b0, hit = 1'b0, lw = 1'b0, mdp = 1'b0;
  logic [7:0] addr = 8'h00, a;
  logic [3:0] be = 4'h0, b, mcmd;
  logic [31:0] wd = 32'h0000_0000, rdata, r, d;
  logic [5:0] fire = 6'h00;
  logic [4:0] evt;
  logic [9:0] x;
  logic [15:0] e_cmd, e_flg, o, m, clr;
  logic ack, start, sel_oe, sel_out, serr_oe, perr_oe, line_seen, perr_n, serr_n, sel_n;
  logic bme, mre, serr_out, perr_out;
  integer mismatches = 0, n_tests = 0, cyc = 0, i;
  always #2.5 I_MCLK = ~I_MCLK;
  pcs_cmd_status_regs u_dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CFG_WR(wr), .I_CFG_RD(rd),
    .I_CFG_ADDR(addr), .I_CFG_BE(be), .I_CFG_WDATA(wd), .O_CFG_RDATA(rdata), .O_CFG_ACK(ack),
    .I_ADDR_PARITY_ERR(evt[0]), .I_DATA_PARITY_ERR(evt[1]),
    .I_PARITY_ERROR_LINE_SEEN(line_seen), .I_MASTER_DATA_PHASE(mdp),
    .I_MASTER_ABORT(evt[2]), .I_TARGET_ABORT_RCVD(evt[3]), .I_TARGET_ABORT_SENT(evt[4]),
    .I_MASTER_REQ(req), .I_MASTER_LINE_WRITE(lw), .O_MASTER_START(start),
    .O_MASTER_CMD(mcmd), .I_MEM_ADDR_HIT(hit), .O_DEVICE_SELECT_LINE_OUT(sel_out),
    .O_DEVICE_SELECT_LINE_OE(sel_oe), .O_SYSTEM_ERROR_OUT(serr_out),
    .O_SYSTEM_ERROR_OUT_OE(serr_oe), .O_PARITY_ERROR_LINE_OUT(perr_out),
    .O_PARITY_ERROR_LINE_OE(perr_oe),
    .O_BUS_MASTER_ENABLE(bme), .O_MEMORY_RESPONSE_ENABLE(mre));
  pcs_bus_agent u_agent (.i_clk(I_MCLK), .i_fire(fire), .i_perr_oe(perr_oe),
    .i_serr_oe(serr_oe), .i_sel_oe(sel_oe), .i_sel_out(sel_out), .o_evt(evt),
    .o_line_seen(line_seen), .o_perr_n(perr_n), .o_serr_n(serr_n), .o_sel_n(sel_n));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction
  // Flags raised by one burst of events
  function automatic logic [15:0] flags_set(input logic [9:0] x, input logic [15:0] o,
                                            input logic [15:0] n);
    return {x[0] | x[1], x[0] & o[8] & n[8], x[2], x[3], x[4], 2'b00,
            ((x[1] & o[6]) | x[5]) & x[9] & n[6], 8'h00};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One config access, events launched alongside
  task automatic acc(input logic w, input logic [7:0] ad, input logic [3:0] bb,
                     input logic [31:0] dd, input logic [9:0] xx);
    @(negedge I_MCLK);
    {wr, rd, addr, be, wd, mdp, lw, hit, req, fire} = {w, ~w, ad, bb, dd, xx};
    @(negedge I_MCLK);
    {wr, rd, fire, req, hit} = 10'h000;
    check(ack, 1'b1);
  endtask
  always @(posedge I_MCLK) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test;
    end
  end
  initial begin
    r = 32'h0000_1d3b;
    e_cmd = 16'h0000;
    e_flg = 16'h0000;
    repeat (6) @(posedge I_MCLK);
    @(negedge I_MCLK);
    I_RST = 1'b0;
    acc(1'b0, 8'h04, 4'hf, 32'h0000_0000, 10'h000);
    check(rdata, 32'h0210_0000);
    for (i = 0; i < 80; i++) begin
      r = lfsr(r);
      d = r;
      r = lfsr(r);
      {x, b} = r[13:0];
      a = r[20] ? 8'h04 : 8'h08;
      if (i < 3) begin
        a = 8'h04;
        b = 4'hf;
        d = (i < 2) ? 32'hffff_ffff : 32'hf900_0000;
        x = (i < 2) ? 10'h3ff : 10'h000;
      end
      o = e_cmd;
      m = {b[1] ? 8'h01 : 8'h00, b[0] ? 8'h56 : 8'h00};
      clr = d[31:16] & {b[3] ? 8'hf9 : 8'h00, 8'h00};
      if (a == 8'h04) begin
        e_cmd = (o & ~m) | (d[15:0] & m);
        e_flg = e_flg & ~clr;
      end
      e_flg = e_flg | flags_set(x, o, e_cmd);
      acc(1'b1, a, b, d, x);
      check(start, x[6] & o[2]);
      check(mcmd, (x[8] & o[4]) ? 4'hf : 4'h7);
      check(serr_n, !(x[0] & o[8]));
      check(perr_oe, x[1] & o[6]);
      check({serr_out, perr_out}, 2'b00);
      @(negedge I_MCLK);
      check(sel_n, !(x[7] & o[1]));
      acc(1'b0, a, 4'hf, 32'h0000_0000, {x[9:8], 8'h00});
      check(rdata, (a == 8'h04) ? {e_flg | 16'h0210, e_cmd} : 32'h0000_0000);
      check({bme, mre}, {e_cmd[2], e_cmd[1]});
    end
    end_of_test;
  end
endmodule // pcs_cmd_status_regs_tb
bind pcs_cmd_status_regs pcs_cmd_status_regs_properties u_props (.I_MCLK, .I_RST,
  .I_CFG_WR, .I_CFG_RD, .I_CFG_ADDR, .O_CFG_RDATA, .I_ADDR_PARITY_ERR, .I_DATA_PARITY_ERR,
  .I_MASTER_ABORT, .I_MASTER_REQ, .I_MASTER_LINE_WRITE, .O_MASTER_START, .O_MASTER_CMD,
  .I_MEM_ADDR_HIT, .O_DEVICE_SELECT_LINE_OUT, .O_DEVICE_SELECT_LINE_OE,
  .O_SYSTEM_ERROR_OUT_OE, .O_PARITY_ERROR_LINE_OE, .O_BUS_MASTER_ENABLE,
  .O_MEMORY_RESPONSE_ENABLE);
`default_nettype wire
